// >>> dcf_video_fifo.sv
// Deep color selection, link unpacking and self-resynchronizing video FIFO
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "dcf_consts.svh"
module dcf_video_fifo (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic tmds_clk_i,
  input wire logic [23:0] link_data_i,
  input wire logic pix_clk_i,
  input wire logic pll_locked_i,
  input wire logic vsync_i,
  input wire logic gcp_valid_i,
  input wire logic [1:0] gcp_depth_i,
  input wire logic [8:0] tmds_freq_mhz_i,
  input wire logic [1:0] bg_depth_i,
  input wire logic bgport_params_valid_i,
  output logic [35:0] pix_data_o,
  output logic pix_valid_o,
  output logic [1:0] active_depth_o,
  output logic digital_pixel_pll_bypass_o,
  output logic [2:0] bgport_select_o,
  output logic bgport_update_request_o,
  output logic irq_o
);
  // ========================================================
  // Synchronisers and edge finders for the pins
  logic [3:0] sa_q, sb_q, sp_q;
  logic [23:0] lda_q, ldb_q;
  logic tmds_rise, pix_rise, lock_rise, vs_rise, lock_s;

  // Two stages; the first stage feeds only the second
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sa_q <= '0;
      sb_q <= '0;
      sp_q <= '0;
      lda_q <= '0;
      ldb_q <= '0;
    end else begin
      sa_q <= {tmds_clk_i, pix_clk_i, pll_locked_i, vsync_i};
      sb_q <= sa_q;
      sp_q <= sb_q;
      lda_q <= link_data_i;
      ldb_q <= lda_q;
    end
  end

  assign tmds_rise = sb_q[3] & ~sp_q[3];
  assign pix_rise = sb_q[2] & ~sp_q[2];
  assign lock_s = sb_q[1];
  assign lock_rise = sb_q[1] & ~sp_q[1];
  assign vs_rise = sb_q[0] & ~sp_q[0];

  // ========================================================
  // AXI4-Lite slave
  logic aw_hold_q, w_hold_q, bvalid_q, awready_q, wready_q;
  logic arready_q, rvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_v;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_go, rd_hit, wr_ok;

  function automatic logic sel(input logic [11:0] a, input logic [7:0] idx);
    sel = (a[11:10] == 2'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
  endfunction : sel

  function automatic logic wsel(input logic [7:0] idx);
    wsel = wr_go && wstrb_q[0] && sel(awaddr_q, idx);
  endfunction : wsel

  assign wr_go = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wr_ok = sel(awaddr_q, `DCF_IDX_FIFO_CTL) | sel(awaddr_q, `DCF_IDX_DEPTH_CTL)
    | sel(awaddr_q, `DCF_IDX_RECENTER) | sel(awaddr_q, `DCF_IDX_CHG)
    | sel(awaddr_q, `DCF_IDX_IRQ_STS) | sel(awaddr_q, `DCF_IDX_IRQ_MSK)
    | sel(awaddr_q, `DCF_IDX_BG_CTL);

  // Address and data are latched separately, so either may come first
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `DCF_RESP_OK;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid_i && awready_q) begin
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_q) begin
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `DCF_RESP_OK : `DCF_RESP_ERR;
      end else if (bvalid_q && s_axi_bready_i) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ========================================================
  // Control and status registers
  logic kill_dis_q, kill_unlk_q, rst_lock_q, ovr_q, recenter_q;
  logic chg_q, chg_p_q, ist_q, imsk_q, bgreq_q, stable_q, irq_q;
  logic [1:0] user_q, pkt_q, bgdepth_q, depth_q, active_d;
  logic [2:0] bgsel_q, level_q;
  logic dc_ev;

  // Software settings; defaults zero on unlock and recenter on lock
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      kill_dis_q <= `DCF_RST_OFF;
      kill_unlk_q <= `DCF_RST_ON;
      rst_lock_q <= `DCF_RST_ON;
      ovr_q <= `DCF_RST_OFF;
      user_q <= dcf_pkg::dcf_d8;
      imsk_q <= `DCF_RST_OFF;
      bgsel_q <= '0;
    end else begin
      if (wsel(`DCF_IDX_FIFO_CTL)) begin
        kill_dis_q <= wdata_q[`DCF_B_KILL_DIS];
        kill_unlk_q <= wdata_q[`DCF_B_KILL_UNLK];
        rst_lock_q <= wdata_q[`DCF_B_RST_LOCK];
      end
      if (wsel(`DCF_IDX_DEPTH_CTL)) begin
        ovr_q <= wdata_q[`DCF_B_OVR];
        user_q <= wdata_q[`DCF_F_USER];
      end
      if (wsel(`DCF_IDX_IRQ_MSK)) begin
        imsk_q <= wdata_q[`DCF_B_IRQ];
      end
      if (wsel(`DCF_IDX_BG_CTL)) begin
        bgsel_q <= wdata_q[`DCF_F_BG_SEL];
      end
    end
  end

  // Self-clearing recenter command and background update request
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      recenter_q <= 1'b0;
      bgreq_q <= 1'b0;
      bgdepth_q <= dcf_pkg::dcf_d8;
    end else begin
      recenter_q <= wsel(`DCF_IDX_RECENTER) & wdata_q[`DCF_B_RECENTER];
      bgreq_q <= wsel(`DCF_IDX_BG_CTL) & wdata_q[`DCF_B_BG_REQ];
      if (bgreq_q) begin
        bgdepth_q <= bg_depth_i;
      end
    end
  end

  // Depth selection; a new depth restarts the unpacker
  assign active_d = ovr_q ? user_q : pkt_q;
  assign dc_ev = depth_q != active_d;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pkt_q <= dcf_pkg::dcf_d8;
      depth_q <= dcf_pkg::dcf_d8;
    end else begin
      if (gcp_valid_i) begin
        pkt_q <= gcp_depth_i;
      end
      depth_q <= active_d;
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chg_q <= 1'b0;
      chg_p_q <= 1'b0;
      ist_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      chg_q <= dc_ev | (chg_q & ~(wsel(`DCF_IDX_CHG) & wdata_q[`DCF_B_CHG]));
      chg_p_q <= chg_q;
      ist_q <= (chg_q & ~chg_p_q)
        | (ist_q & ~(wsel(`DCF_IDX_IRQ_STS) & wdata_q[`DCF_B_IRQ]));
      irq_q <= ist_q & imsk_q;
    end
  end

  // Read data, an if chain over the indices
  always_comb begin
    rd_v = '0;
    rd_hit = 1'b1;
    if (sel(s_axi_araddr_i, `DCF_IDX_FIFO_CTL)) begin
      rd_v[`DCF_B_KILL_DIS] = kill_dis_q;
      rd_v[`DCF_B_KILL_UNLK] = kill_unlk_q;
      rd_v[`DCF_B_RST_LOCK] = rst_lock_q;
    end else if (sel(s_axi_araddr_i, `DCF_IDX_FIFO_STS)) begin
      rd_v[`DCF_F_LEVEL] = level_q;
      rd_v[`DCF_B_STABLE] = stable_q;
    end else if (sel(s_axi_araddr_i, `DCF_IDX_DEPTH_CTL)) begin
      rd_v[`DCF_B_OVR] = ovr_q;
      rd_v[`DCF_F_USER] = user_q;
    end else if (sel(s_axi_araddr_i, `DCF_IDX_RECENTER)) begin
      rd_v[`DCF_B_RECENTER] = recenter_q;
    end else if (sel(s_axi_araddr_i, `DCF_IDX_CHG)) begin
      rd_v[`DCF_B_CHG] = chg_q;
    end else if (sel(s_axi_araddr_i, `DCF_IDX_BG_STS)) begin
      rd_v[`DCF_F_BG_DEPTH] = bgdepth_q;
      rd_v[`DCF_B_BG_VALID] = bgport_params_valid_i;
    end else if (sel(s_axi_araddr_i, `DCF_IDX_PKT_DEPTH)) begin
      rd_v[`DCF_F_DEPTH] = pkt_q;
    end else if (sel(s_axi_araddr_i, `DCF_IDX_IRQ_STS)) begin
      rd_v[`DCF_B_IRQ] = ist_q;
    end else if (sel(s_axi_araddr_i, `DCF_IDX_IRQ_MSK)) begin
      rd_v[`DCF_B_IRQ] = imsk_q;
    end else if (sel(s_axi_araddr_i, `DCF_IDX_BG_CTL)) begin
      rd_v[`DCF_F_BG_SEL] = bgsel_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read channel answers one cycle after the address is taken
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `DCF_RESP_OK;
    end else if (s_axi_arvalid_i && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_v;
      rresp_q <= rd_hit ? `DCF_RESP_OK : `DCF_RESP_ERR;
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ========================================================
  // Unpacker: gathers link bytes into pixels of the active depth
  logic [4:0] cnt_q, wbits, cnt_sum;
  logic [11:0] px_mask;
  logic [23:0] acc_q [3];
  logic [23:0] acc_sum [3];
  logic [35:0] px_d;
  logic emit, wr;

  // Unsupported 16-bit code falls back to 8 bits
  always_comb begin
    case (dcf_pkg::dcf_depth_t'(depth_q))
      dcf_pkg::dcf_d10: wbits = `DCF_BITS_10;
      dcf_pkg::dcf_d12: wbits = `DCF_BITS_12;
      default: wbits = `DCF_LINK_BITS;
    endcase
  end

  assign cnt_sum = cnt_q + `DCF_LINK_BITS;
  assign emit = cnt_sum >= wbits;
  // Keep only the bits of one pixel; carried bits above it belong to the next
  assign px_mask = 12'((13'h0001 << wbits) - 13'h0001);
  assign wr = tmds_rise & emit;

  generate
    for (genvar c = 0; c < 3; c++) begin : g_chan
      assign acc_sum[c] = acc_q[c] | ({16'h0000, ldb_q[c*8 +: 8]} << cnt_q);
      assign px_d[c*12 +: 12] = acc_sum[c][11:0] & px_mask;
      // Leftover bits carry into the next pixel
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          acc_q[c] <= '0;
        end else if (dc_ev) begin
          acc_q[c] <= '0;
        end else if (tmds_rise) begin
          acc_q[c] <= emit ? acc_sum[c] >> wbits : acc_sum[c];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else if (dc_ev) begin
      cnt_q <= '0;
    end else if (tmds_rise) begin
      cnt_q <= emit ? cnt_sum - wbits : cnt_sum;
    end
  end

  // ========================================================
  // FIFO: eight entries, Gray pointer copies for the level
  logic [35:0] mem_q [8];
  logic [2:0] wp_q, rp_q, rp_d, wg_q, rg_q, wp_b, rp_b;
  logic rd, about, resync, zero, kill_q, seen_q, bypass_q;
  logic [4:0] win_q;
  logic [35:0] pix_q;
  logic pixv_q;

  function automatic logic [2:0] g2b(input logic [2:0] g);
    g2b = {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
  endfunction : g2b

  assign wp_b = g2b(wg_q);
  assign rp_b = g2b(rg_q);
  assign rd = bypass_q ? tmds_rise : pix_rise;
  assign about = (wr & (3'(wp_q + 3'h1) == rp_b)) | (rd & (rp_q == wp_b));
  assign resync = about | recenter_q | (lock_rise & rst_lock_q);
  assign rp_d = resync ? 3'(wp_q - `DCF_CENTER) : (rd ? 3'(rp_q + 3'h1) : rp_q);
  assign zero = (kill_q & ~kill_dis_q) | (~lock_s & kill_unlk_q);

  // Write side
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wp_q <= '0;
      wg_q <= '0;
      for (int i = 0; i < 8; i++) mem_q[i] <= '0;
    end else if (wr) begin
      mem_q[wp_q] <= px_d;
      wp_q <= 3'(wp_q + 3'h1);
      wg_q <= 3'(wp_q + 3'h1) ^ (3'(wp_q + 3'h1) >> 1);
    end
  end

  // Read side; recentering puts the read pointer half a FIFO behind the write pointer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rp_q <= 3'(3'h0 - `DCF_CENTER);
      rg_q <= 3'(3'h0 - `DCF_CENTER) ^ (3'(3'h0 - `DCF_CENTER) >> 1); // Gray of reset pointer
      pix_q <= '0;
      pixv_q <= 1'b0;
      bypass_q <= 1'b0;
    end else begin
      rp_q <= rp_d;
      rg_q <= rp_d ^ (rp_d >> 1);
      pixv_q <= rd;
      if (rd) begin
        pix_q <= zero ? '0 : mem_q[rp_q];
      end
      bypass_q <= tmds_freq_mhz_i > `DCF_BYPASS_MHZ;
    end
  end

  // Level, output kill window and frame stability
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      level_q <= '0;
      kill_q <= 1'b0;
      win_q <= `DCF_WIN_WR;
      seen_q <= 1'b0;
      stable_q <= 1'b0;
    end else begin
      if (about) begin
        level_q <= '0;
      end else if (wr | rd) begin
        level_q <= 3'(rp_b - wp_b);
      end
      if (about) begin
        kill_q <= win_q < `DCF_WIN_WR;
        win_q <= '0;
      end else if (win_q == `DCF_WIN_WR) begin
        kill_q <= 1'b0;
      end else if (wr) begin
        win_q <= 5'(win_q + 5'h01);
      end
      if (vs_rise) begin
        stable_q <= ~(seen_q | resync);
        seen_q <= resync;
      end else begin
        seen_q <= seen_q | resync;
      end
    end
  end

  // ========================================================
  // Outputs
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign pix_data_o = pix_q;
  assign pix_valid_o = pixv_q;
  assign active_depth_o = depth_q;
  assign digital_pixel_pll_bypass_o = bypass_q;
  assign bgport_select_o = bgsel_q;
  assign bgport_update_request_o = bgreq_q;
  assign irq_o = irq_q;

  // ========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_depth_auto: assert property (!ovr_q |=> active_depth_o == $past(pkt_q))
    else $error("depth not from packet");
  a_depth_manual: assert property (ovr_q |=> active_depth_o == $past(user_q))
    else $error("depth not from manual field");
  a_chg_sticky: assert property ($changed(active_depth_o) |-> chg_q)
    else $error("depth change not flagged");
  a_irq_status: assert property ($rose(chg_q) |=> ist_q ##1 irq_o == imsk_q)
    else $error("irq status not set");
  a_bg_capture: assert property (bgreq_q |=> bgdepth_q == $past(bg_depth_i))
    else $error("bg depth not captured");
  a_bypass_sel: assert property (tmds_freq_mhz_i > `DCF_BYPASS_MHZ |=> digital_pixel_pll_bypass_o)
    else $error("pll not bypassed");
  a_level_zero: assert property (about |=> level_q == 3'h0)
    else $error("level not zero after resync");
  a_stable_clr: assert property (vs_rise && seen_q |=> !stable_q)
    else $error("stable kept after resync");
  a_recenter_ptr: assert property (recenter_q |=> rp_q == 3'($past(wp_q) - `DCF_CENTER))
    else $error("recenter did not move pointer");
  a_recenter_self: assert property (recenter_q && !wr_go |=> !recenter_q)
    else $error("recenter bit stuck");
  a_zero_unlock: assert property (rd && !lock_s && kill_unlk_q |=> pix_data_o == '0)
    else $error("data passed while unlocked");
  a_gray_step: assert property ($changed(wg_q) |-> $onehot(wg_q ^ $past(wg_q)))
    else $error("write gray moved more than one bit");

  c_resync: cover property (about);
  c_stable: cover property (vs_rise ##1 stable_q);
  c_depth_chg: cover property (dc_ev ##2 ist_q);
  c_kill: cover property ($rose(kill_q));
endmodule : dcf_video_fifo

// >>> dcf_consts.svh
// Register indices, field positions, reset values and counts of the deep color video FIFO
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define DCF_IDX_FIFO_CTL 8'h1B
`define DCF_IDX_FIFO_STS 8'h1C
`define DCF_IDX_DEPTH_CTL 8'h40
`define DCF_IDX_RECENTER 8'h5A
`define DCF_IDX_CHG 8'h83
`define DCF_IDX_BG_STS 8'hEA
`define DCF_IDX_PKT_DEPTH 8'hF0
`define DCF_IDX_IRQ_STS 8'hF1
`define DCF_IDX_IRQ_MSK 8'hF2
`define DCF_IDX_BG_CTL 8'hF3
// ==========================================================
// Field positions
`define DCF_B_KILL_DIS 2
`define DCF_B_KILL_UNLK 3
`define DCF_B_RST_LOCK 4
`define DCF_F_LEVEL 2:0
`define DCF_B_STABLE 3
`define DCF_B_OVR 6
`define DCF_F_USER 5:4
`define DCF_B_RECENTER 2
`define DCF_B_CHG 7
`define DCF_F_BG_DEPTH 3:2
`define DCF_B_BG_VALID 0
`define DCF_F_DEPTH 1:0
`define DCF_B_IRQ 0
`define DCF_F_BG_SEL 2:0
`define DCF_B_BG_REQ 4
// ==========================================================
// Reset values and counts
`define DCF_RST_ON 1'b1
`define DCF_RST_OFF 1'b0
`define DCF_CENTER 3'h4
`define DCF_WIN_WR 5'h10
`define DCF_LINK_BITS 5'h08
`define DCF_BITS_10 5'h0A
`define DCF_BITS_12 5'h0C
`define DCF_BYPASS_MHZ 9'h0AA
`define DCF_RESP_OK 2'h0
`define DCF_RESP_ERR 2'h2
`endif

// >>> dcf_pkg.sv
// Types shared by the deep color video FIFO
package dcf_pkg;
  // ========================================================
  // Color depth codes
  typedef enum logic [1:0] {
    dcf_d8 = 2'h0,
    dcf_d10 = 2'h1,
    dcf_d12 = 2'h2,
    dcf_d16 = 2'h3
  } dcf_depth_t;
endpackage : dcf_pkg

// >>> dcf_link_model.sv
// Upstream link source and pixel clock source for the video FIFO bench
`timescale 1ns/1ps
module dcf_link_model (
  input wire logic run_i,
  output logic tmds_clk_o,
  output logic [23:0] link_data_o,
  output logic pix_clk_o
);
  // ==========
  // Link clock stands still while run_i is low and always parks low
  initial begin
    tmds_clk_o = 1'b0;
    pix_clk_o = 1'b0;
    link_data_o = 24'h00_0000;
    #13;
    forever begin
      #40;
      if (run_i || tmds_clk_o) begin
        tmds_clk_o = ~tmds_clk_o;
        // One byte per lane each link cycle, changed away from the rising edge
        if (!tmds_clk_o) link_data_o = link_data_o + 24'h01_0305;
      end else begin
        // Idle lanes keep toggling so a stale byte never looks valid
        link_data_o = ~link_data_o;
      end
      pix_clk_o = run_i ? ~pix_clk_o : 1'b0;
    end
  end
endmodule : dcf_link_model

// >>> dcf_video_fifo_test.sv
// Self-checking bench for the deep color video FIFO
`timescale 1ns/1ps
`include "dcf_consts.svh"
module dcf_video_fifo_test;
  // ==========
  // Stimulus, observed outputs and reference state
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] aw_addr = 12'h0, ar_addr = 12'h0;
  logic [31:0] w_data = 32'h0, r_data, rd_d, rng = 32'h547e_66b1;
  logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, pix_valid, bypass, bg_req, irq;
  logic [1:0] b_resp, r_resp, rd_r, depth, gcp_depth = 2'h0, bg_depth = 2'h0, man = 2'h0;
  logic gcp_valid = 1'b0, pll_lock = 1'b0, vsync = 1'b0, bg_valid = 1'b0, run = 1'b0;
  logic ovr = 1'b0, tmds_clk, pix_clk;
  logic [35:0] pix_data;
  logic [2:0] bg_sel;
  logic [8:0] freq = 9'h0;
  logic [23:0] link;
  logic [23:0] prev, nx;
  logic [35:0] ex;
  logic seq_on = 1'b0;
  int err_count = 0, comparisons = 0, n_val = 0, n_nz = 0, pkt = 0, n_req = 0;

  // 100 MHz system clock
  always #5 clk_i = ~clk_i;

  dcf_link_model u_link (.run_i(run), .tmds_clk_o(tmds_clk), .link_data_o(link),
    .pix_clk_o(pix_clk));

  dcf_video_fifo dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .s_axi_awaddr_i(aw_addr),
    .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(aw_ready), .s_axi_wdata_i(w_data),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_valid), .s_axi_wready_o(w_ready),
    .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_valid), .s_axi_bready_i(b_ready),
    .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid), .s_axi_arready_o(ar_ready),
    .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_valid),
    .s_axi_rready_i(r_ready), .tmds_clk_i(tmds_clk), .link_data_i(link),
    .pix_clk_i(pix_clk), .pll_locked_i(pll_lock), .vsync_i(vsync),
    .gcp_valid_i(gcp_valid), .gcp_depth_i(gcp_depth), .tmds_freq_mhz_i(freq),
    .bg_depth_i(bg_depth), .bgport_params_valid_i(bg_valid), .pix_data_o(pix_data),
    .pix_valid_o(pix_valid), .active_depth_o(depth), .digital_pixel_pll_bypass_o(bypass),
    .bgport_select_o(bg_sel), .bgport_update_request_o(bg_req), .irq_o(irq));

  // Count pixels and update pulses; in the locked 8-bit stream every pixel
  // must be the next link word, whose bytes the model steps by 24'h01_0305
  always @(posedge clk_i) begin
    if (bg_req === 1'b1) n_req++;
    if (pix_valid === 1'b1) begin
      n_val++;
      if (pix_data !== 36'h0) n_nz++;
      nx = 24'(prev + 24'h01_0305);
      ex = {4'h0, nx[23:16], 4'h0, nx[15:8], 4'h0, nx[7:0]};
      if (seq_on) check("pixel", pix_data, ex);
      prev = {pix_data[31:24], pix_data[19:12], pix_data[7:0]};
    end
  end

  task automatic check(input string nm, input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Reference depth selection
  function automatic logic [1:0] exp_depth();
    return ovr ? man : pkt[1:0];
  endfunction : exp_depth

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] ix, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    aw_addr <= {2'b00, ix, 2'b00};
    aw_valid <= 1'b1;
    w_data <= d;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (aw_ready) aw_valid <= 1'b0;
      if (w_ready) w_valid <= 1'b0;
    end while (b_valid !== 1'b1 && n < 40);
    b_ready <= 1'b0;
    if (n >= 40) begin
      err_count++;
      print_verdict();
    end
    check("bresp", b_resp, er);
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [7:0] ix, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    ar_addr <= {2'b00, ix, 2'b00};
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (ar_ready) ar_valid <= 1'b0;
    end while (r_valid !== 1'b1 && n < 40);
    d = r_data;
    r = r_resp;
    r_ready <= 1'b0;
    if (n >= 40) begin
      err_count++;
      print_verdict();
    end
    @(posedge clk_i);
  endtask : rd

  task automatic rc(input logic [7:0] ix, input logic [31:0] m, input logic [31:0] e,
    input string nm);
    rd(ix, rd_d, rd_r);
    check(nm, rd_d & m, e);
  endtask : rc

  task automatic gcp(input logic [1:0] d);
    gcp_depth <= d;
    gcp_valid <= 1'b1;
    @(posedge clk_i);
    gcp_valid <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : gcp

  task automatic vs();
    vsync <= 1'b1;
    repeat (4) @(posedge clk_i);
    vsync <= 1'b0;
    repeat (300) @(posedge clk_i);
  endtask : vs

  task automatic flow();
    n_val = 0;
    n_nz = 0;
    repeat (600) @(posedge clk_i);
  endtask : flow

  // ==========
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    rc(`DCF_IDX_FIFO_CTL, 32'h1c, 32'h18, "ctl");
    rc(`DCF_IDX_DEPTH_CTL, 32'h70, 32'h0, "dctl");
    rc(`DCF_IDX_FIFO_STS, 32'hf, 32'h0, "sts");
    rd(8'h10, rd_d, rd_r);
    check("unmapped", rd_r, `DCF_RESP_ERR);
    wr(`DCF_IDX_FIFO_STS, 32'h7, `DCF_RESP_ERR);
    // Depth changes back to back; mask opened after the first
    for (int i = 0; i < 3; i++) begin
      pkt = (i + 1) % 3;
      gcp(pkt[1:0]);
      check("depth", depth, exp_depth());
      check("irq", irq, i > 0);
      rc(`DCF_IDX_PKT_DEPTH, 32'h3, pkt, "pkt");
      rc(`DCF_IDX_CHG, 32'h80, 32'h80, "flag");
      rc(`DCF_IDX_IRQ_STS, 32'h1, 32'h1, "irqst");
      wr(`DCF_IDX_CHG, 32'h80, `DCF_RESP_OK);
      wr(`DCF_IDX_IRQ_STS, 32'h1, `DCF_RESP_OK);
      rc(`DCF_IDX_CHG, 32'h80, 32'h0, "flagclr");
      check("irqclr", irq, 1'b0);
      wr(`DCF_IDX_IRQ_MSK, 32'h1, `DCF_RESP_OK);
    end
    man = 2'h2;
    wr(`DCF_IDX_DEPTH_CTL, 32'h20, `DCF_RESP_OK);
    check("noovr", depth, exp_depth());
    ovr = 1'b1;
    pkt = 1;
    wr(`DCF_IDX_DEPTH_CTL, 32'h60, `DCF_RESP_OK);
    gcp(2'h1);
    check("ovr", depth, exp_depth());
    rc(`DCF_IDX_CHG, 32'h80, 32'h80, "ovrflag");
    ovr = 1'b0;
    wr(`DCF_IDX_DEPTH_CTL, 32'h20, `DCF_RESP_OK);
    check("back", depth, exp_depth());
    // Background depth held until the next update request
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      bg_depth <= rng[1:0];
      bg_valid <= rng[2];
      wr(`DCF_IDX_BG_CTL, {27'h0, 2'b10, rng[6:4]}, `DCF_RESP_OK);
      check("bgsel", bg_sel, rng[6:4]);
      repeat (3) @(posedge clk_i);
      bg_depth <= ~rng[1:0];
      rc(`DCF_IDX_BG_STS, 32'hd, {rng[1:0], 1'b0, rng[2]}, "bgsts");
    end
    check("bgreq", n_req, 4);
    // Unlocked link: unlock zeroing, then kill on frequent resyncs
    wr(`DCF_IDX_FIFO_CTL, 32'h1c, `DCF_RESP_OK);
    run <= 1'b1;
    flow();
    check("valid", n_val > 0, 1'b1);
    check("unlkzero", n_nz, 0);
    wr(`DCF_IDX_FIFO_CTL, 32'h14, `DCF_RESP_OK);
    flow();
    check("unlkpass", n_nz > 0, 1'b1);
    pkt = 2;
    gcp(2'h2);
    wr(`DCF_IDX_FIFO_CTL, 32'h10, `DCF_RESP_OK);
    repeat (300) @(posedge clk_i);
    flow();
    check("kill", n_nz, 0);
    for (int f = 169; f < 173; f++) begin
      freq <= f[8:0];
      repeat (4) @(posedge clk_i);
      check("bypass", bypass, f > 170);
    end
    // Locked steady stream, recenter and relock
    pkt = 0;
    gcp(2'h0);
    wr(`DCF_IDX_FIFO_CTL, 32'h18, `DCF_RESP_OK);
    pll_lock <= 1'b1;
    vs();
    // Lock recentering is over; the stream must now run in order
    seq_on = 1'b1;
    n_val = 0;
    vs();
    vs();
    seq_on = 1'b0;
    check("stream", n_val > 0, 1'b1);
    rc(`DCF_IDX_FIFO_STS, 32'h8, 32'h8, "stable");
    wr(`DCF_IDX_RECENTER, 32'h4, `DCF_RESP_OK);
    rc(`DCF_IDX_RECENTER, 32'h4, 32'h0, "recself");
    vs();
    rc(`DCF_IDX_FIFO_STS, 32'h8, 32'h0, "recstab");
    pll_lock <= 1'b0;
    repeat (20) @(posedge clk_i);
    pll_lock <= 1'b1;
    vs();
    rc(`DCF_IDX_FIFO_STS, 32'h8, 32'h0, "lockrec");
    wr(`DCF_IDX_FIFO_CTL, 32'h08, `DCF_RESP_OK);
    vs();
    pll_lock <= 1'b0;
    repeat (20) @(posedge clk_i);
    pll_lock <= 1'b1;
    vs();
    rc(`DCF_IDX_FIFO_STS, 32'h8, 32'h8, "nolockrec");
    print_verdict();
  end
endmodule : dcf_video_fifo_test
